//--- rtl/vbw_pkg.sv
package vbw_pkg;
  localparam int unsigned CLK_MHZ = 40;
  // Power-up pause in microseconds and derived cycles (least time, round up)
  localparam int unsigned PWRUP_US = 500;
  localparam int unsigned PWRUP_CYC = PWRUP_US * CLK_MHZ;
  localparam int unsigned WAKE_CNT = 8;
  localparam int unsigned SCLK_CNT = 8;
  // Strobe phase lengths in cycles; each covers the row/column strobe
  // minimums of the slowest grade at 25 ns per cycle
  localparam logic [3:0] T_RP = 4'h4;
  localparam logic [3:0] T_RCD = 4'h2;
  localparam logic [3:0] T_CAS = 4'h2;
  localparam logic [3:0] T_RSH = 4'h2;
  localparam logic [3:0] T_SC = 4'h1;
  localparam int unsigned ROW_W = 9;
  localparam int unsigned COL_W = 8;
  localparam int unsigned DQ_W = 8;
  localparam int unsigned GRP_LSB = 2;

  typedef enum logic [1:0] {
    VBW_OP_BLOCK = 2'b00,
    VBW_OP_LOAD_COLOR = 2'b01,
    VBW_OP_WAKE = 2'b10
  } vbw_op_t;

  typedef struct packed {
    vbw_op_t op;
    logic [ROW_W-1:0] row;
    logic [5:0] group;
    logic [3:0] col_en;
    logic use_mask;
    logic [DQ_W-1:0] mask;
    logic [DQ_W-1:0] color;
  } vbw_req_t;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic mask_write_select;
    logic oe_n;
    logic special_function_select;
    logic serial_shift_clock;
    logic [ROW_W-1:0] addr;
    logic [DQ_W-1:0] dq;
    logic dq_oe;
  } vbw_pins_t;
endpackage : vbw_pkg

//--- rtl/vbw_phase_timer.sv
`timescale 1ns/100ps
`default_nettype none
module vbw_phase_timer (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic [3:0] len_i,
  output logic done_o
);
  import vbw_pkg::*;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  assign next_cnt = load_i ? len_i : (cnt != 4'h0 ? cnt - 4'h1 : 4'h0);
  // Plain compare: gating with load would loop back through next_state
  assign done_o = (cnt == 4'h1);
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cnt <= 4'h0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule : vbw_phase_timer
`default_nettype wire

//--- rtl/vbw_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Color register loaded before block writes
// - Drive ignored address and data bits valid
// - 500 us pause, eight strobes, eight shifts
// - Strobes during pause do not shorten it
// - Eight strobes after long row inactivity
// - Special-function select picks special cycles
module vbw_ctrl #(
  parameter int unsigned PWRUP_CYCLES = vbw_pkg::PWRUP_CYC,
  parameter int unsigned IDLE_CYCLES = 320000
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire vbw_pkg::vbw_req_t req_i,
  output logic req_ready_o,
  output logic ready_o,
  output logic color_loaded_o,
  output logic refused_o,
  output vbw_pkg::vbw_pins_t pins_o
);
  import vbw_pkg::*;

  typedef enum logic [3:0] {
    S_PAUSE = 4'b0000,
    S_WK_PRE = 4'b0001,
    S_WK_RAS = 4'b0010,
    S_SC_HI = 4'b0011,
    S_SC_LO = 4'b0100,
    S_IDLE = 4'b0101,
    S_PRE = 4'b0110,
    S_RAS = 4'b0111,
    S_CAS = 4'b1000,
    S_RSH = 4'b1001
  } vbw_state_t;

  // Rest levels: both strobes, mask-write select and output enable high, special-function select low, bus released
  localparam vbw_pins_t PINS_IDLE = '{
    ras_n: 1'b1,
    cas_n: 1'b1,
    mask_write_select: 1'b1,
    oe_n: 1'b1,
    default: '0
  };

  vbw_state_t state;
  vbw_state_t next_state;
  vbw_req_t cur;
  vbw_pins_t pins;
  logic [31:0] pause_cnt;
  logic [31:0] idle_cnt;
  logic [3:0] wake_left;
  logic [3:0] sc_left;
  logic powered;
  logic color_ok;
  logic tmr_load;
  logic [3:0] tmr_len;
  logic tmr_done;

  //////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] phase_len(input vbw_state_t s);
    case (s)
      S_PRE, S_WK_PRE: phase_len = T_RP;
      S_RAS, S_WK_RAS: phase_len = T_RCD;
      S_CAS: phase_len = T_CAS;
      S_SC_HI, S_SC_LO: phase_len = T_SC;
      default: phase_len = T_RSH;
    endcase
  endfunction : phase_len

  vbw_phase_timer u_timer (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(tmr_load),
    .len_i(tmr_len),
    .done_o(tmr_done)
  );

  wire pause_done = (pause_cnt >= PWRUP_CYCLES);
  wire idle_long = (idle_cnt >= IDLE_CYCLES);
  wire is_block = (req_i.op == VBW_OP_BLOCK);
  wire bad_req = req_valid_i && is_block && !color_ok;
  wire accept = (state == S_IDLE) && req_valid_i && !bad_req && !idle_long;
  wire cur_block = (cur.op == VBW_OP_BLOCK);

  assign req_ready_o = (state == S_IDLE) && !bad_req && !idle_long;
  // Reload on every phase change so each phase runs its full length
  assign tmr_load = (state != next_state) || (state == S_PAUSE);
  assign tmr_len = phase_len(next_state);

  // Wake-up and cycle bookkeeping
  wire wake_start = (next_state == S_WK_PRE) &&
    (state == S_PAUSE || state == S_IDLE);
  wire wake_step = (state == S_WK_RAS) && tmr_done;
  wire sc_start = (state == S_WK_RAS) && (next_state == S_SC_HI);
  wire sc_step = (state == S_SC_LO) && tmr_done;
  wire enter_idle = (state != S_IDLE) && (next_state == S_IDLE);
  wire load_done = (state == S_RSH) && tmr_done && !cur_block;

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    case (state)
      S_PAUSE: if (pause_done) next_state = S_WK_PRE;
      S_WK_PRE: if (tmr_done) next_state = S_WK_RAS;
      S_WK_RAS: begin
        if (tmr_done) begin
          if (wake_left != 4'h1) next_state = S_WK_PRE;
          else if (!powered) next_state = S_SC_HI;
          else next_state = S_IDLE;
        end
      end
      S_SC_HI: if (tmr_done) next_state = S_SC_LO;
      S_SC_LO: begin
        if (tmr_done) next_state = (sc_left == 4'h1) ? S_IDLE : S_SC_HI;
      end
      S_IDLE: begin
        if (idle_long) next_state = S_WK_PRE;
        else if (accept) next_state = S_PRE;
      end
      S_PRE: if (tmr_done) next_state = S_RAS;
      S_RAS: if (tmr_done) next_state = S_CAS;
      S_CAS: if (tmr_done) next_state = S_RSH;
      S_RSH: if (tmr_done) next_state = S_IDLE;
      default: next_state = S_PAUSE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    // Undriven fields rest low; strobes, mask-write select and output enable high
    pins = '0;
    pins.ras_n = 1'b1;
    pins.cas_n = 1'b1;
    pins.mask_write_select = 1'b1;
    pins.oe_n = 1'b1;
    case (state)
      S_WK_RAS: pins.ras_n = 1'b0;
      S_SC_HI: pins.serial_shift_clock = 1'b1;
      S_PRE, S_RAS: begin
        pins.ras_n = (state != S_RAS);
        pins.addr = cur.row;
        // raised at row strobe for every request that is not a block write
        pins.special_function_select = !cur_block;
        pins.mask_write_select = !(cur_block && cur.use_mask);
        pins.dq = cur.mask;
        pins.dq_oe = 1'b1;
      end
      S_CAS, S_RSH: begin
        pins.ras_n = 1'b0;
        pins.cas_n = (state != S_CAS);
        pins.mask_write_select = 1'b0;
        pins.special_function_select = 1'b1;
        pins.dq_oe = 1'b1;
        if (cur_block) begin
          // group address, low bits held low
          pins.addr = {1'b0, cur.group, 2'b00};
          // column enables, upper lines held low
          pins.dq = {4'h0, cur.col_en};
        end else begin
          pins.dq = cur.color;
        end
      end
      default: pins.ras_n = 1'b1;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state <= S_PAUSE;
      pause_cnt <= 32'h0;
      idle_cnt <= 32'h0;
      wake_left <= 4'h0;
      sc_left <= 4'h0;
      powered <= 1'b0;
      color_ok <= 1'b0;
      cur <= '0;
      pins_o <= PINS_IDLE;
      refused_o <= 1'b0;
    end else begin
      state <= next_state;
      pins_o <= pins;
      // Pulses once for every idle cycle a refused request is offered
      refused_o <= bad_req && (state == S_IDLE);
      if (!pause_done) pause_cnt <= pause_cnt + 32'h1;
      if (!pins.ras_n) idle_cnt <= 32'h0;
      else if (!idle_long) idle_cnt <= idle_cnt + 32'h1;
      if (wake_start)
        wake_left <= 4'(WAKE_CNT);
      else if (wake_step)
        wake_left <= wake_left - 4'h1;
      if (sc_start)
        sc_left <= 4'(SCLK_CNT);
      else if (sc_step)
        sc_left <= sc_left - 4'h1;
      if (enter_idle) powered <= 1'b1;
      if (accept) cur <= req_i;
      if (load_done) color_ok <= 1'b1;
    end
  end

  // Low during any wake-up, so no request can cut it short
  assign ready_o = powered && (state == S_IDLE) && !idle_long;
  assign color_loaded_o = color_ok;
endmodule : vbw_ctrl
`default_nettype wire

//--- dv/vbw_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module vbw_chk (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire vbw_pkg::vbw_req_t req_i,
  input wire logic req_ready_o,
  input wire logic ready_o,
  input wire logic color_loaded_o,
  input wire logic refused_o,
  input wire vbw_pkg::vbw_pins_t pins_o
);
  import vbw_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic pend;
  vbw_req_t m;
  // Wake strobes must not be judged as block cycles
  always_ff @(posedge ref_clk_i) begin
    if (req_valid_i && req_ready_o) m <= req_i;
    if (sys_rst_i || !pins_o.cas_n) pend <= 1'b0;
    else if (req_valid_i && req_ready_o) pend <= req_i.op == VBW_OP_BLOCK;
  end
  a_refuse_cause: assert property (refused_o |->
    $past(req_valid_i) && !$past(color_loaded_o)) else $error("bad refusal");
  a_ras_mask: assert property ($fell(pins_o.ras_n) && pend |->
    pins_o.mask_write_select == !m.use_mask && !pins_o.special_function_select
    && (!m.use_mask || pins_o.dq == m.mask)) else $error("bad row strobe");
  a_cas_group: assert property ($fell(pins_o.cas_n) && pend |->
    pins_o.addr[7:2] == m.group && pins_o.dq[3:0] == m.col_en)
    else $error("bad column group");
  a_cas_special: assert property ($fell(pins_o.cas_n) && pend |->
    pins_o.special_function_select && pins_o.addr[1:0] == 2'h0
    && pins_o.dq[7:4] == 4'h0) else $error("bad column strobe");
  a_ras_lead: assert property ($fell(pins_o.cas_n) |->
    !$past(pins_o.ras_n) && $past(pins_o.ras_n, 3)) else $error("early cas");
  a_cas_width: assert property ($fell(pins_o.cas_n) |=>
    !pins_o.cas_n ##1 pins_o.cas_n) else $error("bad cas width");
  a_ras_precharge: assert property ($rose(pins_o.ras_n) |=>
    pins_o.ras_n [*3]) else $error("short precharge");
  a_req_busy: assert property (req_valid_i && req_ready_o |=>
    !req_ready_o [*8]) else $error("taken twice");
endmodule : vbw_chk
bind vbw_ctrl vbw_chk i_chk (.ref_clk_i, .sys_rst_i, .req_valid_i, .req_i,
  .req_ready_o, .ready_o, .color_loaded_o, .refused_o, .pins_o);
`default_nettype wire

//--- dv/vbw_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module vbw_dev_model (
  input wire vbw_pkg::vbw_pins_t pins_i
);
  import vbw_pkg::*;
  logic [7:0] mem [int];
  logic [7:0] color, mask;
  logic [8:0] row;
  logic wpb, lcr;
  int kk;
  int n_ras = 0;
  int n_sc = 0;
  // mode and mask
  // Guard skips edges while output enable is still unknown before reset
  always @(negedge pins_i.ras_n) if (pins_i.oe_n) begin
    row = pins_i.addr;
    wpb = !pins_i.mask_write_select;
    lcr = pins_i.special_function_select;
    if (wpb) mask = pins_i.dq;
    n_ras++;
  end
  always @(posedge pins_i.serial_shift_clock) if (pins_i.oe_n) n_sc++;
  always @(negedge pins_i.cas_n) if (lcr) color = pins_i.dq;
  else if (pins_i.special_function_select) begin
    for (int i = 0; i < 4; i++) if (pins_i.dq[i]) begin
      kk = int'({row, pins_i.addr[7:2], 2'(i)});
      mem[kk] = wpb ? (color & mask) | (mem[kk] & ~mask) : color;
    end
  end
endmodule : vbw_dev_model
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import vbw_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  vbw_req_t req_i = '0;
  logic req_ready_o, ready_o, color_loaded_o, refused_o;
  vbw_pins_t pins_o;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int first_ras = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) cyc <= cyc + 1;
  // First row strobe shows whether the power-up pause was kept
  always @(negedge pins_o.ras_n) if (first_ras == 0) first_ras = cyc;
  // Short pause and idle limit keep the run small
  vbw_ctrl #(.PWRUP_CYCLES(20), .IDLE_CYCLES(300)) i_dut (.ref_clk_i,
    .sys_rst_i, .req_valid_i, .req_i, .req_ready_o, .ready_o,
    .color_loaded_o, .refused_o, .pins_o);
  vbw_dev_model i_dev (.pins_i(pins_o));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input bit dev);
    for (int i = 0; i < 600 && (dev ? ready_o : req_ready_o) !== 1'b1; i++)
      @(negedge ref_clk_i);
    chk(dev ? ready_o : req_ready_o, 1);
  endtask : wt
  function automatic int k(input logic [5:0] g, input int c);
    return int'({9'h0C3, g, c[1:0]});
  endfunction : k
  task automatic go(input vbw_op_t op, input logic [5:0] g,
      input logic [3:0] e, input logic u, input logic [7:0] v);
    wt(0);
    req_i = '{op, 9'h0C3, g, e, u, 8'h0F, v};
    req_valid_i = 1'b1;
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
    @(negedge ref_clk_i);
    wt(0);
  endtask : go
  //////////////////////////////////////////////////////////////////////////
  task automatic t_init;
    wt(1);
    chk(first_ras >= 25, 1);
    chk(i_dev.n_ras >= 8 && i_dev.n_sc >= 8, 1);
    $display("test init finished");
  endtask : t_init
  task automatic t_refuse;
    req_valid_i = 1'b1;
    @(negedge ref_clk_i);
    chk(refused_o, 1);
    req_valid_i = 1'b0;
    @(negedge ref_clk_i);
    chk({color_loaded_o, pins_o.ras_n}, 2'h1);
    $display("test refuse finished");
  endtask : t_refuse
  task automatic t_block;
    go(VBW_OP_LOAD_COLOR, 6'h3F, 4'h0, 1'b0, 8'hA5);
    chk(color_loaded_o, 1);
    go(VBW_OP_BLOCK, 6'h3F, 4'hF, 1'b0, 8'h00);
    go(VBW_OP_LOAD_COLOR, 6'h3F, 4'h0, 1'b0, 8'h3C);
    go(VBW_OP_BLOCK, 6'h3F, 4'h5, 1'b0, 8'h00);
    go(VBW_OP_BLOCK, 6'h00, 4'h1, 1'b0, 8'h00);
    for (int c = 0; c < 4; c++)
      chk(i_dev.mem[k(6'h3F, c)], c[0] ? 8'hA5 : 8'h3C);
    chk(i_dev.mem[k(6'h00, 0)], 8'h3C);
    $display("test block finished");
  endtask : t_block
  task automatic t_mask;
    go(VBW_OP_BLOCK, 6'h3F, 4'h2, 1'b1, 8'h00);
    chk(i_dev.mem[k(6'h3F, 1)], 8'hAC);
    chk(i_dev.mem[k(6'h3F, 0)], 8'h3C);
    $display("test mask finished");
  endtask : t_mask
  task automatic t_idle;
    int n0;
    n0 = i_dev.n_ras;
    repeat (400) @(negedge ref_clk_i);
    wt(1);
    chk(i_dev.n_ras - n0 >= 8, 1);
    go(VBW_OP_BLOCK, 6'h01, 4'h8, 1'b0, 8'h00);
    chk(i_dev.mem[k(6'h01, 3)], 8'h3C);
    $display("test idle finished");
  endtask : t_idle
  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  initial begin
    repeat (5) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    t_init();
    t_refuse();
    t_block();
    t_mask();
    t_idle();
    results();
  end
  // Tests need about 600 cycles
  initial begin
    repeat (4000) @(posedge ref_clk_i);
    n_mismatch++;
    results();
  end
endmodule : tb
`default_nettype wire
